// ---- rtl/irq_ctrl.sv ----
`include "irq_map.svh"
`default_nettype none
module irq_ctrl #(
  parameter int NSRC = 11
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Machine cycle timing from the sequencer
  input wire logic mc_sample_i,
  input wire logic last_cycle_i,
  input wire logic cfg_write_instr_i,
  input wire logic irq_return_i,
  input wire logic plain_return_i,
  // External pins, active low
  input wire logic ext_irq_pin0_n_i,
  input wire logic ext_irq_pin1_n_i,
  // Peripheral events
  input wire logic tmr0_overflow_i,
  input wire logic tmr1_overflow_i,
  input wire logic uart_rx_done_i,
  input wire logic uart_tx_done_i,
  input wire logic hdlc_rx_valid_i,
  input wire logic hdlc_rx_error_i,
  input wire logic dma0_done_i,
  input wire logic hdlc_tx_valid_i,
  input wire logic dma1_done_i,
  input wire logic hdlc_tx_error_i,
  // Call sequence to the sequencer
  output logic call_active_o,
  output logic call_push_o,
  output logic call_load_o,
  output logic [7:0] call_vector_o,
  output logic pc_pop_o,
  output logic [1:0] in_service_o
);
  localparam irq_pkg::vector_t VEC_TAB [0:10] = `VEC_TABLE;

  // Registers
  logic [7:0] core_irq_enable_r;
  logic [4:0] core_irq_rank_r;
  logic [5:0] extra_irq_enable_r;
  logic [5:0] extra_irq_rank_r;
  logic ext0_edge_mode_r;
  logic ext1_edge_mode_r;
  logic ext0_req_flag_r;
  logic ext1_req_flag_r;
  logic tmr0_overflow_flag_r;
  logic tmr1_overflow_flag_r;
  logic uart_rx_flag_r;
  logic uart_tx_flag_r;
  logic [5:0] extra_flag_r;
  logic [1:0] pin_prev_r;
  logic [NSRC-1:0] smp_req_r;
  logic [1:0] ins_r;
  logic blk_seen_r;
  irq_pkg::call_state_t call_state_r;
  irq_pkg::call_state_t call_state_nxt;
  irq_pkg::vector_t vector_r;
  irq_pkg::src_idx_t last_idx_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic call_active_r;
  logic call_push_r;
  logic call_load_r;
  logic pc_pop_r;

  // Bus decode
  logic bus_req;
  logic bus_wr;
  logic wr_core_en;
  logic wr_core_rank;
  logic wr_extra_en;
  logic wr_extra_rank;
  logic wr_tmr;
  logic wr_uart;
  logic wr_extra_flag;
  logic cfg_wr_now;
  logic [7:0] wbyte;
  logic [31:0] rd_data;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign bus_wr = bus_req & wb_we_i & ack_r & wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];
  assign wr_core_en = bus_wr & (wb_adr_i == `ADR_CORE_EN);
  assign wr_core_rank = bus_wr & (wb_adr_i == `ADR_CORE_RANK);
  assign wr_extra_en = bus_wr & (wb_adr_i == `ADR_EXTRA_EN);
  assign wr_extra_rank = bus_wr & (wb_adr_i == `ADR_EXTRA_RANK);
  assign wr_tmr = bus_wr & (wb_adr_i == `ADR_TMR_CTRL);
  assign wr_uart = bus_wr & (wb_adr_i == `ADR_UART_CTRL);
  assign wr_extra_flag = bus_wr & (wb_adr_i == `ADR_EXTRA_FLAG);
  assign cfg_wr_now = wr_core_en | wr_core_rank | wr_extra_en | wr_extra_rank;

  // Read mux, unmapped reads as zero
  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      `ADR_CORE_EN: rd_data[7:0] = core_irq_enable_r;
      `ADR_CORE_RANK: rd_data[4:0] = core_irq_rank_r;
      `ADR_EXTRA_EN: rd_data[5:0] = extra_irq_enable_r;
      `ADR_EXTRA_RANK: rd_data[5:0] = extra_irq_rank_r;
      `ADR_TMR_CTRL: rd_data[7:0] = {tmr1_overflow_flag_r, 1'b0, tmr0_overflow_flag_r, 1'b0,
                                     ext1_req_flag_r, ext1_edge_mode_r,
                                     ext0_req_flag_r, ext0_edge_mode_r};
      `ADR_UART_CTRL: rd_data[1:0] = {uart_tx_flag_r, uart_rx_flag_r};
      `ADR_EXTRA_FLAG: rd_data[5:0] = extra_flag_r;
      `ADR_STATUS: rd_data[15:0] = {vector_r, last_idx_r, 1'b0, call_active_r, ins_r};
      default: rd_data = '0;
    endcase
  end

  // Resolver link
  irq_req_if #(.NSRC(NSRC)) rq ();
  irq_resolver #(.NSRC(NSRC)) u_resolver (
    .rq(rq)
  );

  // Call decision
  logic issue;
  logic level_ok;
  logic clr_ext0;
  logic clr_ext1;
  logic clr_tmr0;
  logic clr_tmr1;
  // R16 equal or higher level in service blocks
  assign level_ok = rq.win_high ? ~ins_r[1] : ~(ins_r[1] | ins_r[0]);
  // R17 R18 final cycle, no config write or interrupt return
  assign issue = mc_sample_i & (call_state_r == irq_pkg::CALL_IDLE) & rq.win_valid & level_ok
               & last_cycle_i & ~cfg_write_instr_i & ~blk_seen_r & ~cfg_wr_now
               & ~irq_return_i;
  // R06 edge-mode external flags only
  assign clr_ext0 = issue & (rq.win_idx == `SRC_EXT0) & ext0_edge_mode_r;
  assign clr_ext1 = issue & (rq.win_idx == `SRC_EXT1) & ext1_edge_mode_r;
  // R08 timer flags cleared on vectoring
  assign clr_tmr0 = issue & (rq.win_idx == `SRC_TMR0);
  assign clr_tmr1 = issue & (rq.win_idx == `SRC_TMR1);

  // Hardware set terms, all taken at the late sample phase
  logic set_ext0;
  logic set_ext1;
  logic set_tmr0;
  logic set_tmr1;
  logic set_rx;
  logic set_tx;
  logic [5:0] extra_evt;
  // R24 falling edge across two samples, else low level
  assign set_ext0 = mc_sample_i & ~ext_irq_pin0_n_i & (~ext0_edge_mode_r | pin_prev_r[0]);
  assign set_ext1 = mc_sample_i & ~ext_irq_pin1_n_i & (~ext1_edge_mode_r | pin_prev_r[1]);
  // R09 timer flags at late sample phase
  assign set_tmr0 = mc_sample_i & tmr0_overflow_i;
  assign set_tmr1 = mc_sample_i & tmr1_overflow_i;
  assign set_rx = mc_sample_i & uart_rx_done_i;
  assign set_tx = mc_sample_i & uart_tx_done_i;
  assign extra_evt = {hdlc_tx_error_i, dma1_done_i, hdlc_tx_valid_i,
                      dma0_done_i, hdlc_rx_error_i, hdlc_rx_valid_i};

  // Flag next values; a hardware set beats any clear
  logic ext0_flag_nxt;
  logic ext1_flag_nxt;
  logic tmr0_flag_nxt;
  logic tmr1_flag_nxt;
  logic rx_flag_nxt;
  logic tx_flag_nxt;
  logic [5:0] extra_flag_nxt;
  // R11 software writes any flag
  // R07 level-mode flag left for software
  assign ext0_flag_nxt = (wr_tmr ? wbyte[`BIT_EXT0_FLAG] : (ext0_req_flag_r & ~clr_ext0))
                       | set_ext0;
  assign ext1_flag_nxt = (wr_tmr ? wbyte[`BIT_EXT1_FLAG] : (ext1_req_flag_r & ~clr_ext1))
                       | set_ext1;
  assign tmr0_flag_nxt = (wr_tmr ? wbyte[`BIT_TMR0_FLAG] : (tmr0_overflow_flag_r & ~clr_tmr0))
                       | set_tmr0;
  assign tmr1_flag_nxt = (wr_tmr ? wbyte[`BIT_TMR1_FLAG] : (tmr1_overflow_flag_r & ~clr_tmr1))
                       | set_tmr1;
  // R10 serial flags never cleared by hardware
  assign rx_flag_nxt = (wr_uart ? wbyte[`BIT_UART_RX] : uart_rx_flag_r) | set_rx;
  assign tx_flag_nxt = (wr_uart ? wbyte[`BIT_UART_TX] : uart_tx_flag_r) | set_tx;

  // Per-bit extra flags
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_extra
      assign extra_flag_nxt[g] = (wr_extra_flag ? wbyte[g] : extra_flag_r[g])
                               | (mc_sample_i & extra_evt[g]);
    end
  endgenerate

  // R01 eleven sources in tie order
  logic [NSRC-1:0] flag_vec;
  logic [NSRC-1:0] en_vec;
  logic [NSRC-1:0] rank_vec;
  logic uart_req;
  // R10 serial request is rx OR tx
  assign uart_req = rx_flag_nxt | tx_flag_nxt;
  assign flag_vec = {uart_req, extra_flag_nxt[5], tmr1_flag_nxt, extra_flag_nxt[4],
                     extra_flag_nxt[3], ext1_flag_nxt, extra_flag_nxt[2],
                     extra_flag_nxt[1], tmr0_flag_nxt, extra_flag_nxt[0], ext0_flag_nxt};
  // R02 R03 per-source enables
  assign en_vec = {core_irq_enable_r[4], extra_irq_enable_r[5], core_irq_enable_r[3],
                   extra_irq_enable_r[4], extra_irq_enable_r[3], core_irq_enable_r[2],
                   extra_irq_enable_r[2], extra_irq_enable_r[1], core_irq_enable_r[1],
                   extra_irq_enable_r[0], core_irq_enable_r[0]};
  // R04 R05 level per source
  assign rank_vec = {core_irq_rank_r[4], extra_irq_rank_r[5], core_irq_rank_r[3],
                     extra_irq_rank_r[4], extra_irq_rank_r[3], core_irq_rank_r[2],
                     extra_irq_rank_r[2], extra_irq_rank_r[1], core_irq_rank_r[1],
                     extra_irq_rank_r[0], core_irq_rank_r[0]};
  assign rq.req = smp_req_r;
  assign rq.high = rank_vec;

  // Call sequencer next state
  always_comb begin
    call_state_nxt = call_state_r;
    case (call_state_r)
      irq_pkg::CALL_IDLE: begin
        if (issue) begin
          call_state_nxt = irq_pkg::CALL_PUSH;
        end
      end
      irq_pkg::CALL_PUSH: begin
        if (mc_sample_i) begin
          call_state_nxt = irq_pkg::CALL_LOAD;
        end
      end
      irq_pkg::CALL_LOAD: begin
        if (mc_sample_i) begin
          call_state_nxt = irq_pkg::CALL_IDLE;
        end
      end
      default: call_state_nxt = irq_pkg::CALL_IDLE;
    endcase
  end

  // Wishbone handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= bus_req & ~ack_r;
      dat_r <= rd_data;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_irq_enable_r <= `RST_BYTE;
      core_irq_rank_r <= '0;
      extra_irq_enable_r <= '0;
      extra_irq_rank_r <= '0;
      ext0_edge_mode_r <= 1'b0;
      ext1_edge_mode_r <= 1'b0;
    end else begin
      if (wr_core_en) begin
        core_irq_enable_r <= {wbyte[`BIT_GLOBAL_EN], 2'b00, wbyte[4:0]};
      end
      if (wr_core_rank) begin
        core_irq_rank_r <= wbyte[4:0];
      end
      if (wr_extra_en) begin
        extra_irq_enable_r <= wbyte[5:0];
      end
      if (wr_extra_rank) begin
        extra_irq_rank_r <= wbyte[5:0];
      end
      if (wr_tmr) begin
        ext0_edge_mode_r <= wbyte[`BIT_EXT0_EDGE];
        ext1_edge_mode_r <= wbyte[`BIT_EXT1_EDGE];
      end
    end
  end

  // Request flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext0_req_flag_r <= 1'b0;
      ext1_req_flag_r <= 1'b0;
      tmr0_overflow_flag_r <= 1'b0;
      tmr1_overflow_flag_r <= 1'b0;
      uart_rx_flag_r <= 1'b0;
      uart_tx_flag_r <= 1'b0;
      extra_flag_r <= '0;
    end else begin
      ext0_req_flag_r <= ext0_flag_nxt;
      ext1_req_flag_r <= ext1_flag_nxt;
      tmr0_overflow_flag_r <= tmr0_flag_nxt;
      tmr1_overflow_flag_r <= tmr1_flag_nxt;
      uart_rx_flag_r <= rx_flag_nxt;
      uart_tx_flag_r <= tx_flag_nxt;
      extra_flag_r <= extra_flag_nxt;
    end
  end

  // R15 R19 fresh sample each late phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_req_r <= '0;
      pin_prev_r <= 2'b00;
      blk_seen_r <= 1'b0;
    end else if (mc_sample_i) begin
      // R02 global enable masks all
      smp_req_r <= flag_vec & en_vec & {NSRC{core_irq_enable_r[`BIT_GLOBAL_EN]}};
      pin_prev_r <= {ext_irq_pin1_n_i, ext_irq_pin0_n_i};
      blk_seen_r <= 1'b0;
    end else if (cfg_wr_now | irq_return_i) begin
      // R18 remember a blocking event this cycle
      blk_seen_r <= 1'b1;
    end
  end

  // R25 R22 in-service per level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ins_r <= 2'b00;
    end else if (issue) begin
      ins_r <= ins_r | {rq.win_high, ~rq.win_high};
    end else if (irq_return_i) begin
      ins_r <= ins_r[1] ? {1'b0, ins_r[0]} : 2'b00;
    end
  end

  // R20 R23 two-cycle call with vector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      call_state_r <= irq_pkg::CALL_IDLE;
      vector_r <= '0;
      last_idx_r <= '0;
      call_active_r <= 1'b0;
      call_push_r <= 1'b0;
      call_load_r <= 1'b0;
    end else begin
      call_state_r <= call_state_nxt;
      call_active_r <= call_state_nxt != irq_pkg::CALL_IDLE;
      call_push_r <= issue;
      call_load_r <= (call_state_r == irq_pkg::CALL_LOAD) & mc_sample_i;
      if (issue) begin
        // R14 vector lookup
        vector_r <= VEC_TAB[rq.win_idx];
        last_idx_r <= rq.win_idx;
      end
    end
  end

  // R21 both returns pop the stack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_pop_r <= 1'b0;
    end else begin
      pc_pop_r <= irq_return_i | plain_return_i;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign call_active_o = call_active_r;
  assign call_push_o = call_push_r;
  assign call_load_o = call_load_r;
  assign call_vector_o = vector_r;
  assign pc_pop_o = pc_pop_r;
  assign in_service_o = ins_r;
endmodule
`default_nettype wire

// ---- rtl/irq_map.svh ----
// Overview of operation
// R01: Eleven request sources feed the controller
// R02: Core enable bits; bit 7 masks all
// R03: Extra enable register at 0xC8, six sources
// R04: Extra rank register at 0xF8, same bits
// R05: Core rank bits pick high level
// R06: Edge-mode external flag cleared on vectoring
// R07: Level-mode external flag cleared by software
// R08: Timer flags raise requests, cleared on vectoring
// R09: Timer flags set at late sample phase
// R10: Serial request is rx OR tx, software-cleared
// R11: Software may set any request flag
// R12: Two levels; high never pre-empted by low
// R13: Fixed tie order within one level
// R14: Fixed vector address per source
// R15: Sample late phase, resolve next machine cycle
// R16: No call under equal/higher level service
// R17: Call only in final instruction cycle
// R18: No call on config write or return; the code blocks on an interrupt return only, not on a plain return
// R19: Denied requests are not remembered
// R20: Call pushes PC, loads winner vector
// R21: Return pops stack top into PC
// R22: Only interrupt return ends in-service state
// R23: Call spans two machine cycles
// R24: Edge flag on high-then-low pin samples
// R25: One in-service bit per level
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
// Register byte addresses
`define ADR_CORE_EN 8'h00
`define ADR_CORE_RANK 8'h04
`define ADR_TMR_CTRL 8'h08
`define ADR_UART_CTRL 8'h0C
`define ADR_EXTRA_FLAG 8'h10
`define ADR_STATUS 8'h14
`define ADR_EXTRA_EN 8'hC8
`define ADR_EXTRA_RANK 8'hF8
// Field positions
`define BIT_GLOBAL_EN 7
`define BIT_EXT0_EDGE 0
`define BIT_EXT0_FLAG 1
`define BIT_EXT1_EDGE 2
`define BIT_EXT1_FLAG 3
`define BIT_TMR0_FLAG 5
`define BIT_TMR1_FLAG 7
`define BIT_UART_RX 0
`define BIT_UART_TX 1
// Reset values
`define RST_BYTE 8'h00
// Source index in tie order
`define SRC_EXT0 4'h0
`define SRC_TMR0 4'h2
`define SRC_EXT1 4'h5
`define SRC_TMR1 4'h8
// Vector per source index
`define VEC_TABLE '{8'h03, 8'h2B, 8'h0B, 8'h33, 8'h3B, 8'h13, 8'h43, 8'h53, 8'h1B, 8'h4B, 8'h23}
`endif

// ---- rtl/irq_pkg.sv ----
`default_nettype none
package irq_pkg;
  typedef logic [3:0] src_idx_t;
  typedef logic [7:0] vector_t;
  typedef enum logic [1:0] {CALL_IDLE, CALL_PUSH, CALL_LOAD} call_state_t;
endpackage
`default_nettype wire

// ---- rtl/irq_req_if.sv ----
`default_nettype none
interface irq_req_if #(parameter int NSRC = 11);
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] high;
  logic win_valid;
  logic win_high;
  irq_pkg::src_idx_t win_idx;
  modport ctrl (output req, output high, input win_valid, input win_high, input win_idx);
  modport resolver (input req, input high, output win_valid, output win_high, output win_idx);
endinterface
`default_nettype wire

// ---- rtl/irq_resolver.sv ----
`default_nettype none
module irq_resolver #(
  parameter int NSRC = 11
) (
  irq_req_if.resolver rq
);
  logic [NSRC-1:0] hi_req;
  logic [NSRC-1:0] lo_req;
  logic [NSRC-1:0] cand;
  logic [NSRC-1:0] pick;
  logic any_hi;
  irq_pkg::src_idx_t idx;

  // Split by level; high level wins over low
  assign hi_req = rq.req & rq.high;
  assign lo_req = rq.req & ~rq.high;
  assign any_hi = |hi_req;
  // R12 level select
  assign cand = any_hi ? hi_req : lo_req;

  // R13 lowest index wins
  genvar i;
  generate
    for (i = 0; i < NSRC; i++) begin : g_pick
      if (i == 0) begin : g_first
        assign pick[i] = cand[i];
      end else begin : g_rest
        assign pick[i] = cand[i] & ~(|cand[i-1:0]);
      end
    end
  endgenerate

  // One-hot to index
  always_comb begin
    idx = '0;
    for (int k = 0; k < NSRC; k++) begin
      if (pick[k]) begin
        idx = idx | irq_pkg::src_idx_t'(k);
      end
    end
  end

  assign rq.win_idx = idx;
  assign rq.win_valid = |cand;
  assign rq.win_high = any_hi;
endmodule
`default_nettype wire

// ---- bench/irq_ctrl_props.sv ----
`default_nettype none
module irq_ctrl_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sequencer side
  input wire logic mc_sample_i,
  input wire logic last_cycle_i,
  input wire logic cfg_write_instr_i,
  input wire logic irq_return_i,
  input wire logic plain_return_i,
  input wire logic call_push_o,
  input wire logic call_load_o,
  input wire logic pc_pop_o,
  input wire logic [1:0] in_service_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] smp_r;
  logic [1:0] smp_nxt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Machine cycles seen since the last push, saturating
  assign smp_nxt = (mc_sample_i && smp_r != 2'h3) ? smp_r + 2'h1 : smp_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || call_push_o) smp_r <= 2'h0;
    else smp_r <= smp_nxt;
  end
  // Bus answers after one wait and only for one cycle
  ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered after one wait");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("unused read data bits not zero");
  call_gate_a: assert property (call_push_o |->
    $past(mc_sample_i) && $past(last_cycle_i) && !$past(cfg_write_instr_i))
    else $error("call issued outside a permitted poll");
  call_span_a: assert property (call_load_o |-> smp_r == 2'h2)
    else $error("vector load not two machine cycles after push");
  load_bound_a: assert property (call_push_o |-> ##[2:400] call_load_o)
    else $error("vector load missing after push");
  level_gate_a: assert property (call_push_o |-> !$past(in_service_o[1]) &&
    (in_service_o[1] || $past(in_service_o) == 2'h0))
    else $error("call issued under equal or higher service");
  pop_follow_a: assert property (irq_return_i || plain_return_i |=> pc_pop_o)
    else $error("return without stack pop");
  plain_keep_a: assert property (plain_return_i && !irq_return_i |=>
    $stable(in_service_o))
    else $error("plain return changed service state");
  ret_clear_a: assert property (irq_return_i |=> in_service_o ==
    ($past(in_service_o[1]) ? {1'b0, $past(in_service_o[0])} : 2'h0))
    else $error("interrupt return cleared wrong level");
  // Main scenarios reached
  nest_c: cover property (call_push_o && in_service_o == 2'h3);
  plain_c: cover property (plain_return_i && in_service_o != 2'h0);
  load_c: cover property (call_load_o);
endmodule
bind irq_ctrl irq_ctrl_props irq_ctrl_props_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mc_sample_i(mc_sample_i), .last_cycle_i(last_cycle_i),
  .cfg_write_instr_i(cfg_write_instr_i), .irq_return_i(irq_return_i),
  .plain_return_i(plain_return_i), .call_push_o(call_push_o), .call_load_o(call_load_o),
  .pc_pop_o(pc_pop_o), .in_service_o(in_service_o));
`default_nettype wire

// ---- bench/core_seq_model.sv ----
`default_nettype none
module core_seq_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic last_en_i,
  // Call sequence from the controller
  input wire logic push_i,
  input wire logic load_i,
  input wire logic [7:0] vector_i,
  input wire logic pop_i,
  // Timing and program counter
  output logic mc_sample_o,
  output logic last_cycle_o,
  output logic [15:0] pc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_r;
  logic [2:0] sp_r;
  logic [15:0] stk_r [8];
  assign mc_sample_o = (phase_r == 2'h3);
  assign last_cycle_o = last_en_i;
  // Machine cycle phase, stack and program counter; stack wraps like the real one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= 2'h0;
      sp_r <= 3'h0;
      pc_o <= 16'h1000;
      foreach (stk_r[k]) stk_r[k] <= 16'h1000;
    end else begin
      phase_r <= phase_r + 2'h1;
      if (push_i) begin
        stk_r[sp_r] <= pc_o;
        sp_r <= sp_r + 3'h1;
      end
      if (load_i) pc_o <= {8'h00, vector_i};
      if (pop_i) begin
        pc_o <= stk_r[sp_r - 3'h1];
        sp_r <= sp_r - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/irq_ctrl_test.sv ----
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module irq_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RA [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'hC8, 8'hF8, 8'h20};
  localparam logic [7:0] WA [5] = '{8'h00, 8'h04, 8'hC8, 8'hF8, 8'h20};
  localparam logic [7:0] WE [5] = '{8'h9F, 8'h1F, 8'h3F, 8'h3F, 8'h00};
  localparam logic [7:0] FR [11] = '{8'h08, 8'h10, 8'h08, 8'h10, 8'h10, 8'h08, 8'h10, 8'h10,
    8'h08, 8'h10, 8'h0C};
  localparam logic [7:0] FB [11] = '{8'h02, 8'h01, 8'h20, 8'h02, 8'h04, 8'h08, 8'h08, 8'h10,
    8'h80, 8'h20, 8'h03};
  localparam logic [7:0] VE [11] = '{8'h03, 8'h2B, 8'h0B, 8'h33, 8'h3B, 8'h13, 8'h43, 8'h53,
    8'h1B, 8'h4B, 8'h23};
  localparam logic [7:0] EV [10] = '{8'h0B, 8'h1B, 8'h23, 8'h23, 8'h2B, 8'h33, 8'h3B, 8'h43,
    8'h53, 8'h4B};
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, cfg_w = 1'b0, last_en = 1'b1;
  logic iret = 1'b0, pret = 1'b0, pin0_n = 1'b1, pin1_n = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [9:0] ev = 10'h0;
  logic ack, mc_smp, last_c, push, load, pop, act;
  logic [7:0] vec, rdat;
  logic [31:0] dat_o;
  logic [1:0] insvc;
  logic [15:0] pc;
  logic [7:0] sh [8];
  int bad_count = 0, n_checks = 0, n_calls = 0, ticks = 0;
  irq_ctrl irq_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .mc_sample_i(mc_smp), .last_cycle_i(last_c), .cfg_write_instr_i(cfg_w),
    .irq_return_i(iret), .plain_return_i(pret), .ext_irq_pin0_n_i(pin0_n),
    .ext_irq_pin1_n_i(pin1_n), .tmr0_overflow_i(ev[0]), .tmr1_overflow_i(ev[1]),
    .uart_rx_done_i(ev[2]), .uart_tx_done_i(ev[3]), .hdlc_rx_valid_i(ev[4]),
    .hdlc_rx_error_i(ev[5]), .dma0_done_i(ev[6]), .hdlc_tx_valid_i(ev[7]),
    .dma1_done_i(ev[8]), .hdlc_tx_error_i(ev[9]), .call_active_o(act), .call_push_o(push),
    .call_load_o(load), .call_vector_o(vec), .pc_pop_o(pop), .in_service_o(insvc));
  core_seq_model core_seq_model_inst (.clk_i(clk_i), .rst_i(rst_i), .last_en_i(last_en),
    .push_i(push), .load_i(load), .vector_i(vec), .pop_i(pop), .mc_sample_o(mc_smp),
    .last_cycle_o(last_c), .pc_o(pc));
  // Clock
  initial forever #10 clk_i = ~clk_i;
  // Call counter and hang limit
  always @(posedge clk_i) begin
    if (push === 1'b1) begin
      n_calls++;
      `CHK(act, 1'b1)
    end
    if (load === 1'b1) `CHK(act, 1'b0)
    ticks++;
    if (ticks == 30000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // Only ack, or else the bench timeout, ends this wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = dat_o[7:0];
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(rdat, e)
  endtask
  task automatic mcw(input int n);
    repeat (n) begin
      @(posedge clk_i);
      while (mc_smp !== 1'b1) @(posedge clk_i);
    end
  endtask
  // No call may start over the next machine cycles
  task automatic quiet(input int n);
    int c;
    c = n_calls;
    mcw(n);
    `CHK(n_calls, c)
  endtask
  task automatic expect_call(input logic [7:0] v, input logic [1:0] s);
    int t;
    t = 0;
    while (load !== 1'b1 && t < 200) begin
      @(posedge clk_i);
      t++;
    end
    @(posedge clk_i);
    `CHK(t < 200, 1'b1)
    `CHK(vec, v)
    `CHK(pc, {8'h00, v})
    `CHK(insvc, s)
  endtask
  task automatic ret(input logic irq);
    if (irq) iret <= 1'b1;
    else pret <= 1'b1;
    @(posedge clk_i);
    iret <= 1'b0;
    pret <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (RA[i]) rd(RA[i], 8'h00);
    foreach (WA[i]) begin
      wb(1'b1, WA[i], 8'hFF);
      rd(WA[i], WE[i]);
    end
    wb(1'b1, 8'h04, 8'h00);
    wb(1'b1, 8'hF8, 8'h00);
    wb(1'b1, 8'h00, 8'h1F);
    sh[2] = 8'hAF;
    sh[3] = 8'h03;
    sh[4] = 8'h3F;
    for (int k = 2; k < 5; k++) wb(1'b1, {3'h0, k[2:0], 2'h0}, sh[k]);
    quiet(4);
    wb(1'b1, 8'h00, 8'h9F);
    for (int i = 0; i < 11; i++) begin
      expect_call(VE[i], 2'b01);
      if (FR[i] == 8'h08) sh[2] &= ~FB[i];
      rd(FR[i], sh[FR[i][4:2]]);
      sh[FR[i][4:2]] &= ~FB[i];
      wb(1'b1, FR[i], sh[FR[i][4:2]]);
      ret(1'b1);
      `CHK(pc, 16'h1000)
    end
    last_en <= 1'b0;
    wb(1'b1, 8'h0C, 8'h01);
    quiet(4);
    wb(1'b1, 8'h0C, 8'h00);
    mcw(1); // Let one fresh sample pass
    last_en <= 1'b1;
    quiet(4);
    cfg_w <= 1'b1;
    wb(1'b1, 8'h0C, 8'h02);
    quiet(4);
    cfg_w <= 1'b0;
    expect_call(8'h23, 2'b01);
    wb(1'b1, 8'h0C, 8'h00);
    ret(1'b1);
    foreach (EV[i]) begin
      ev[i] <= 1'b1;
      repeat (4) @(posedge clk_i);
      ev[i] <= 1'b0;
      expect_call(EV[i], 2'b01);
      rd(8'h08, 8'h05);
      wb(1'b1, 8'h0C, 8'h00);
      wb(1'b1, 8'h10, 8'h00);
      ret(1'b1);
    end
    wb(1'b1, 8'h08, 8'h01);
    pin1_n <= 1'b0;
    expect_call(8'h13, 2'b01);
    rd(8'h08, 8'h09);
    pin1_n <= 1'b1;
    wb(1'b1, 8'h08, 8'h01);
    ret(1'b1);
    pin0_n <= 1'b0;
    expect_call(8'h03, 2'b01);
    rd(8'h08, 8'h01);
    pin0_n <= 1'b1;
    ret(1'b1);
    wb(1'b1, 8'h04, 8'h08);
    wb(1'b1, 8'h08, 8'h87);
    expect_call(8'h1B, 2'b10);
    quiet(4);
    ret(1'b0);
    `CHK(insvc, 2'b10)
    quiet(3);
    ret(1'b1);
    expect_call(8'h03, 2'b01);
    wb(1'b1, 8'h08, 8'h85);
    expect_call(8'h1B, 2'b11);
    rd(8'h14, 8'h83);
    ret(1'b1);
    `CHK(insvc, 2'b01)
    `CHK(pc, 16'h0003)
    ret(1'b1);
    `CHK(insvc, 2'b00)
    print_verdict();
  end
endmodule
`default_nettype wire
